//--- verilog/rsc_pkg.sv
package rsc_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int RSC_CLK_PERIOD_NS = 10;
  localparam int RSC_RST_HOLD_NS = 100;
  localparam int RSC_RST_HOLD_CYC = (RSC_RST_HOLD_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam int RSC_HOLD_W = 4;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] RSC_ADDR_CAUSE = 16'hf001;
  localparam logic [15:0] RSC_ADDR_UNLOCK = 16'hf008;
  localparam logic [15:0] RSC_ADDR_STBY = 16'hf009;
  localparam logic [15:0] RSC_ADDR_BLK_A = 16'hf028;
  localparam logic [15:0] RSC_ADDR_BLK_B = 16'hf02a;
  localparam logic [15:0] RSC_ADDR_BLK_C = 16'hf02c;
  localparam logic [15:0] RSC_ADDR_BLK_D = 16'hf02e;
  localparam logic [15:0] RSC_ADDR_BLK_E = 16'hf02f;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int RSC_WDT_FLAG_BIT = 2;
  localparam int RSC_POR_FLAG_BIT = 0;
  localparam int RSC_STOP_BIT = 1;
  localparam int RSC_HALT_BIT = 0;
  localparam int RSC_T0_BIT = 0;
  localparam int RSC_T1_BIT = 1;
  localparam logic [7:0] RSC_CAUSE_RST = 8'h01;
  localparam logic [7:0] RSC_BLK_RST = 8'h00;
  localparam logic [7:0] RSC_ZERO = 8'h00;
  localparam logic [7:0] RSC_MASK_A = 8'h03;
  localparam logic [7:0] RSC_MASK_B = 8'h8f;
  localparam logic [7:0] RSC_MASK_C = 8'h61;
  localparam logic [7:0] RSC_MASK_D = 8'h0f;
  localparam logic [7:0] RSC_MASK_E = 8'h03;
  localparam logic [3:0] RSC_KEY_FIRST = 4'h5;
  localparam logic [3:0] RSC_KEY_SECOND = 4'ha;
  localparam logic [15:0] RSC_VEC_SP = 16'h0000;
  localparam logic [15:0] RSC_VEC_PC = 16'h0002;
  localparam logic [15:0] RSC_VEC_PC_BRK = 16'h0004;
  localparam logic [1:0] RSC_BRK_LEVEL_MAX = 2'h1;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {RSC_M_RESET, RSC_M_RUN, RSC_M_HALT, RSC_M_STOP} rsc_mode_t;
  typedef enum logic [1:0] {RSC_U_IDLE, RSC_U_FIRST, RSC_U_ARMED} rsc_unlock_t;
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rsc_sfr_req_t;
  typedef struct packed {
    logic nmi;
    logic wdt;
    logic anyPending;
    logic [3:0] ext;
    logic [3:0] extEnable;
    logic master_irq_enable;
  } rsc_irq_t;
  typedef struct packed {
    logic cpu;
    logic power;
    logic special_function_register;
  } rsc_rst_out_t;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
  } rsc_blk_t;
  typedef struct packed {
    logic pinSync1;
    logic pinSync2;
    rsc_mode_t mode;
    logic fullKind;
    logic [RSC_HOLD_W-1:0] holdCnt;
    rsc_unlock_t unlock;
    logic [7:0] cause;
    rsc_blk_t blk;
    logic [7:0] rdData;
    logic rdValid;
    rsc_rst_out_t rstOut;
    logic [15:0] spVec;
    logic [15:0] pcVec;
    logic haltBit;
    logic stopBit;
    logic wakeNoService;
  } rsc_state_t;
endpackage

//--- verilog/rsc_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - Pin, watchdog overflow or break instruction each enter system reset mode.
// - Break reset restarts only the CPU; RAM and registers keep values.
// - Reset never clears the cause register; only a watchdog reset sets its bit.
// - Bit 2 flags a watchdog reset; software may write it.
// - System reset overrides everything and abandons work in progress.
// - Pin and watchdog resets reset the power circuit; break does not.
// - Pin and watchdog resets restore register initial values; break does not.
// - Reset initialises the CPU and loads the stack pointer from 0000H.
// - Program counter from 0002H; break at level 1 or lower uses 0004H.
// - Data memory and undefined registers are never touched by reset.
// - The stop unlock register is write-only and reads zero.
// - Writing 5nH then 0AnH arms the unlock; other work may intervene.
// - Any other value after 5nH discards it; sequence restarts.
// - Stop bit with unlock armed enters STOP and disarms unlock.
// - Unlock stays disarmed throughout system reset.
// - Unlock cannot arm while an enabled interrupt is pending.
// - NMI or enabled port interrupt clears stop bit and resumes run.
// - Halt bit stops the CPU; NMI, watchdog or enabled interrupt resumes.
// - With master enable low, interrupts release standby without service.
// - HALT and STOP are refused while an enabled interrupt is pending.
// - Block-disable bits hold timers and other blocks in reset, clock stopped.
// - Wake-up clears the halt bit at the next system clock.
module rsc_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic wdtOverflow,
  input wire logic breakExec,
  input wire logic [1:0] interruptLevel,
  input wire rsc_pkg::rsc_irq_t irqIn,
  input wire rsc_pkg::rsc_sfr_req_t sfrReq,
  output logic [7:0] sfrRdata,
  output logic sfrRvalid,
  output rsc_pkg::rsc_rst_out_t rstOut,
  output logic [15:0] spVector,
  output logic [15:0] pcVector,
  output logic haltMode,
  output logic stopMode,
  output logic wakeNoService,
  output rsc_pkg::rsc_blk_t blkDisable
);
  import rsc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  localparam rsc_state_t RSC_STATE_RST = '{
    pinSync1: 1'b1,
    pinSync2: 1'b1,
    mode: RSC_M_RESET,
    fullKind: 1'b1,
    holdCnt: RSC_HOLD_W'(RSC_RST_HOLD_CYC),
    unlock: RSC_U_IDLE,
    cause: RSC_CAUSE_RST,
    blk: '0,
    rdData: 8'h00,
    rdValid: 1'b0,
    rstOut: '{cpu: 1'b1, power: 1'b1, special_function_register: 1'b1},
    spVec: RSC_VEC_SP,
    pcVec: RSC_VEC_PC,
    haltBit: 1'b0,
    stopBit: 1'b0,
    wakeNoService: 1'b0
  };

  rsc_state_t stReg;
  rsc_state_t stNext;

  logic pinRst;
  logic fullCause;
  logic brkCause;
  logic haltWake;
  logic stopWake;
  logic isWr;
  logic isRd;

  function automatic logic keyIs(logic [7:0] d, logic [3:0] key);
    return d[7:4] == key;
  endfunction

  function automatic logic [7:0] readMux(rsc_state_t s, logic [15:0] a);
    logic [7:0] r;
    r = RSC_ZERO;
    unique case (a)
      RSC_ADDR_CAUSE: r = s.cause;
      RSC_ADDR_BLK_A: r = s.blk.a;
      RSC_ADDR_BLK_B: r = s.blk.b;
      RSC_ADDR_BLK_C: r = s.blk.c;
      RSC_ADDR_BLK_D: r = s.blk.d;
      RSC_ADDR_BLK_E: r = s.blk.e;
      default: r = RSC_ZERO; // Unlock, standby and unmapped read zero
    endcase
    return r;
  endfunction

  // ****************************************
  // Cause detection
  // ****************************************
  assign pinRst = !stReg.pinSync2;
  assign fullCause = pinRst || wdtOverflow;
  assign brkCause = breakExec && stReg.mode == RSC_M_RUN;
  assign haltWake = irqIn.nmi || irqIn.wdt || irqIn.anyPending;
  assign stopWake = irqIn.nmi || |(irqIn.ext & irqIn.extEnable);
  // Bus only answers while the CPU runs
  assign isWr = sfrReq.wr && stReg.mode == RSC_M_RUN;
  assign isRd = sfrReq.rd && stReg.mode == RSC_M_RUN;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    stNext = stReg;
    stNext.rdValid = 1'b0;
    stNext.wakeNoService = 1'b0;
    // First stage feeds only the second
    stNext.pinSync1 = resetPinN;
    stNext.pinSync2 = stReg.pinSync1;
    if (fullCause || brkCause) begin
      // Reset wins over any access or mode change
      stNext.mode = RSC_M_RESET;
      stNext.holdCnt = RSC_HOLD_W'(RSC_RST_HOLD_CYC);
      stNext.unlock = RSC_U_IDLE;
      stNext.spVec = RSC_VEC_SP;
      if (wdtOverflow) begin
        stNext.cause[RSC_WDT_FLAG_BIT] = 1'b1;
      end
      if (fullCause) begin
        stNext.fullKind = 1'b1;
        stNext.blk = '0;
        stNext.pcVec = RSC_VEC_PC;
      end else begin
        stNext.fullKind = 1'b0;
        if (interruptLevel <= RSC_BRK_LEVEL_MAX) begin
          stNext.pcVec = RSC_VEC_PC_BRK;
        end else begin
          stNext.pcVec = RSC_VEC_PC;
        end
      end
    end else begin
      unique case (stReg.mode)
        RSC_M_RESET: begin
          stNext.unlock = RSC_U_IDLE;
          stNext.holdCnt = stReg.holdCnt - RSC_HOLD_W'(1);
          if (stReg.holdCnt == RSC_HOLD_W'(1)) begin
            stNext.mode = RSC_M_RUN;
          end
        end
        RSC_M_RUN: begin
          if (isRd) begin
            stNext.rdValid = 1'b1;
            stNext.rdData = readMux(stReg, sfrReq.addr);
          end
          if (isWr) begin
            unique case (sfrReq.addr)
              RSC_ADDR_CAUSE: begin
                // Only the watchdog flag is writable
                stNext.cause[RSC_WDT_FLAG_BIT] = sfrReq.wdata[RSC_WDT_FLAG_BIT];
              end
              RSC_ADDR_UNLOCK: begin
                unique case (stReg.unlock)
                  RSC_U_IDLE: begin
                    if (keyIs(sfrReq.wdata, RSC_KEY_FIRST)) begin
                      stNext.unlock = RSC_U_FIRST;
                    end
                  end
                  RSC_U_FIRST: begin
                    if (keyIs(sfrReq.wdata, RSC_KEY_SECOND) && !irqIn.anyPending) begin
                      stNext.unlock = RSC_U_ARMED;
                    end else begin
                      stNext.unlock = RSC_U_IDLE;
                    end
                  end
                  RSC_U_ARMED: begin
                    stNext.unlock = RSC_U_ARMED;
                  end
                  default: begin
                    // Unused code falls back to idle, never to armed
                    stNext.unlock = RSC_U_IDLE;
                  end
                endcase
              end
              RSC_ADDR_STBY: begin
                // Both bits set is prohibited and ignored
                if (!(sfrReq.wdata[RSC_STOP_BIT] && sfrReq.wdata[RSC_HALT_BIT]) && !irqIn.anyPending) begin
                  if (sfrReq.wdata[RSC_STOP_BIT] && stReg.unlock == RSC_U_ARMED) begin
                    stNext.mode = RSC_M_STOP;
                    stNext.unlock = RSC_U_IDLE;
                  end else if (sfrReq.wdata[RSC_HALT_BIT]) begin
                    stNext.mode = RSC_M_HALT;
                  end
                end
              end
              RSC_ADDR_BLK_A: stNext.blk.a = sfrReq.wdata & RSC_MASK_A;
              RSC_ADDR_BLK_B: stNext.blk.b = sfrReq.wdata & RSC_MASK_B;
              RSC_ADDR_BLK_C: stNext.blk.c = sfrReq.wdata & RSC_MASK_C;
              RSC_ADDR_BLK_D: stNext.blk.d = sfrReq.wdata & RSC_MASK_D;
              RSC_ADDR_BLK_E: stNext.blk.e = sfrReq.wdata & RSC_MASK_E;
              default: begin
                stNext.blk = stReg.blk;
              end
            endcase
          end
        end
        RSC_M_HALT: begin
          // One clock only: release lands on the next rising edge
          if (haltWake) begin
            stNext.mode = RSC_M_RUN;
            stNext.wakeNoService = !irqIn.nmi && !irqIn.wdt && !irqIn.master_irq_enable;
          end
        end
        RSC_M_STOP: begin
          if (stopWake) begin
            stNext.mode = RSC_M_RUN;
            stNext.wakeNoService = !irqIn.nmi && !irqIn.master_irq_enable;
          end
        end
      endcase
    end
    stNext.haltBit = stNext.mode == RSC_M_HALT;
    stNext.stopBit = stNext.mode == RSC_M_STOP;
    stNext.rstOut.cpu = stNext.mode == RSC_M_RESET;
    stNext.rstOut.power = stNext.rstOut.cpu && stNext.fullKind;
    stNext.rstOut.special_function_register = stNext.rstOut.cpu && stNext.fullKind;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stReg <= RSC_STATE_RST;
    end else begin
      stReg <= stNext;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sfrRdata = stReg.rdData;
  assign sfrRvalid = stReg.rdValid;
  assign rstOut = stReg.rstOut;
  assign spVector = stReg.spVec;
  assign pcVector = stReg.pcVec;
  assign haltMode = stReg.haltBit;
  assign stopMode = stReg.stopBit; // Both oscillators stop while high
  assign wakeNoService = stReg.wakeNoService;
  assign blkDisable = stReg.blk; // Timer bits 0 and 1 of block a

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wdt_cause_set_a: assert property (wdtOverflow |=> rstOut.cpu && rstOut.power && stReg.cause[2])
    else $error("watchdog reset not taken or flag not set");

  pin_sync_a: assert property (!resetPinN |-> ##[2:3] rstOut.cpu && rstOut.special_function_register)
    else $error("pin reset not seen within three cycles");

  brk_cpu_only_a: assert property (
    (breakExec && stReg.mode == RSC_M_RUN && !wdtOverflow && stReg.pinSync2)
    |=> rstOut.cpu && !rstOut.power && !rstOut.special_function_register && blkDisable == $past(stReg.blk))
    else $error("break reset touched power or registers");

  brk_vector_a: assert property (
    (breakExec && stReg.mode == RSC_M_RUN && !wdtOverflow && stReg.pinSync2 && interruptLevel <= 2'h1)
    |=> pcVector == 16'h0004)
    else $error("break vector wrong");

  full_vector_a: assert property (wdtOverflow |=> pcVector == 16'h0002 && spVector == 16'h0000)
    else $error("reset vectors wrong");

  reset_priority_a: assert property (
    (fullCause || brkCause) |=> rstOut.cpu && !sfrRvalid && !haltMode && !stopMode)
    else $error("reset did not override activity");

  power_regs_a: assert property (rstOut.power |-> rstOut.cpu && rstOut.special_function_register)
    else $error("power reset without register reset");

  cause_keep_a: assert property (
    ((fullCause || brkCause) && !wdtOverflow) |=> stReg.cause == $past(stReg.cause))
    else $error("cause register changed by other reset");

  full_blk_clear_a: assert property (fullCause |=> blkDisable == '0)
    else $error("block registers kept over full reset");

  // Pin low must not reset before both stages have seen it
  pin_delay_a: assert property (
    (stReg.mode == RSC_M_RUN && stReg.pinSync1 && stReg.pinSync2 && !resetPinN && !wdtOverflow && !breakExec)
    |=> !rstOut.cpu)
    else $error("pin reset bypassed the synchroniser");

  no_access_a: assert property (stReg.mode != RSC_M_RUN |=> !sfrRvalid)
    else $error("access answered outside run mode");

  unlock_reset_a: assert property (rstOut.cpu |-> stReg.unlock != RSC_U_ARMED)
    else $error("unlock armed during reset");

  unlock_read_a: assert property (
    (isRd && (sfrReq.addr == 16'hf008 || sfrReq.addr == 16'hf009) && !fullCause && !breakExec)
    |=> sfrRvalid && sfrRdata == 8'h00)
    else $error("write-only register read nonzero");

  // ****************************************
  // Unlock and standby checks
  // ****************************************
  arm_blocked_a: assert property (
    (isWr && sfrReq.addr == 16'hf008 && irqIn.anyPending && stReg.unlock == RSC_U_FIRST && !fullCause)
    |=> stReg.unlock == RSC_U_IDLE)
    else $error("unlock armed with interrupt pending");

  bad_second_a: assert property (
    (isWr && sfrReq.addr == 16'hf008 && stReg.unlock == RSC_U_FIRST && sfrReq.wdata[7:4] != 4'ha)
    |=> stReg.unlock == RSC_U_IDLE)
    else $error("first unlock code not discarded");

  first_key_a: assert property (
    (isWr && sfrReq.addr == RSC_ADDR_UNLOCK && stReg.unlock == RSC_U_IDLE && sfrReq.wdata[7:4] == 4'h5
     && !fullCause && !breakExec) |=> stReg.unlock == RSC_U_FIRST)
    else $error("first unlock code not taken");

  arm_second_a: assert property (
    (isWr && sfrReq.addr == RSC_ADDR_UNLOCK && stReg.unlock == RSC_U_FIRST && sfrReq.wdata[7:4] == 4'ha
     && !irqIn.anyPending && !fullCause && !breakExec) |=> stReg.unlock == RSC_U_ARMED)
    else $error("unlock not armed by second code");

  stop_entry_a: assert property (
    (isWr && sfrReq.addr == 16'hf009 && sfrReq.wdata[1:0] == 2'b10 && stReg.unlock == RSC_U_ARMED
     && !irqIn.anyPending && !fullCause && !breakExec)
    |=> stopMode && !haltMode && stReg.unlock == RSC_U_IDLE)
    else $error("stop entry wrong");

  stop_locked_a: assert property (
    (isWr && sfrReq.addr == RSC_ADDR_STBY && sfrReq.wdata[1] && stReg.unlock != RSC_U_ARMED) |=> !stopMode)
    else $error("stop entered without unlock");

  halt_entry_a: assert property (
    (isWr && sfrReq.addr == RSC_ADDR_STBY && sfrReq.wdata[1:0] == 2'b01 && !irqIn.anyPending
     && !fullCause && !breakExec) |=> haltMode && !stopMode)
    else $error("halt not entered");

  both_bits_a: assert property (
    (isWr && sfrReq.addr == RSC_ADDR_STBY && sfrReq.wdata[1:0] == 2'b11) |=> !haltMode && !stopMode)
    else $error("prohibited standby code accepted");

  standby_excl_a: assert property (!(haltMode && stopMode))
    else $error("halt and stop both set");

  stop_wake_a: assert property ((stopMode && stopWake && !fullCause) |=> !stopMode && !rstOut.cpu)
    else $error("stop not released");

  stop_hold_a: assert property ((stopMode && !stopWake && !fullCause) |=> stopMode)
    else $error("stop left without wake request");

  halt_wake_a: assert property ((haltMode && haltWake && !fullCause) |=> !haltMode && !rstOut.cpu)
    else $error("halt not released on next clock");

  halt_hold_a: assert property ((haltMode && !haltWake && !fullCause) |=> haltMode)
    else $error("halt left without wake request");

  nmi_service_a: assert property ((haltMode && irqIn.nmi && !fullCause) |=> !wakeNoService)
    else $error("nmi wake flagged as unserviced");

  standby_refused_a: assert property (
    (isWr && sfrReq.addr == 16'hf009 && irqIn.anyPending && !fullCause && !breakExec)
    |=> !haltMode && !stopMode)
    else $error("standby entered with interrupt pending");

  // ****************************************
  // Covers
  // ****************************************
  cover_stop_c: cover property (stopMode ##1 !stopMode);
  cover_arm_c: cover property (stReg.unlock == RSC_U_ARMED);
  cover_halt_c: cover property (haltMode ##1 !haltMode && wakeNoService);
  cover_brk_c: cover property (rstOut.cpu && !rstOut.power);
  cover_wdt_c: cover property (wdtOverflow ##1 stReg.cause[2]);

endmodule // rsc_ctrl

//--- test/rsc_cpu_model.sv
`timescale 1ns/1ns
// ****************************************
// CPU core side: register bus and interrupt lines
// ****************************************
module rsc_cpu_model (
  input wire logic clk,
  output rsc_pkg::rsc_sfr_req_t sfrReq,
  input wire logic [7:0] sfrRdata,
  input wire logic sfrRvalid,
  output rsc_pkg::rsc_irq_t irqIn,
  output logic breakExec,
  output logic [1:0] interruptLevel
);
  import rsc_pkg::*;
  initial begin
    sfrReq <= '0;
    irqIn <= '0;
    breakExec <= 1'b0;
    interruptLevel <= 2'h0;
  end
  // Released lines never keep their last value, so a stale address cannot pass for a held one
  task automatic releaseBus();
    sfrReq <= '{addr: ~sfrReq.addr, wr: 1'b0, rd: 1'b0, wdata: ~sfrReq.wdata};
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    releaseBus();
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    sfrReq <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: sfrReq.wdata};
    @(posedge clk);
    releaseBus();
    #1;
    v = sfrRvalid;
    d = sfrRdata;
  endtask
  task automatic break_instruction(input logic [1:0] lvl);
    @(posedge clk);
    breakExec <= 1'b1;
    interruptLevel <= lvl;
    @(posedge clk);
    breakExec <= 1'b0;
  endtask
  task automatic setIrq(input rsc_irq_t v);
    @(posedge clk);
    irqIn <= v;
  endtask
endmodule // rsc_cpu_model

//--- test/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
  import rsc_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resetPinN = 1'b1;
  logic wdtOverflow = 1'b0;
  rsc_sfr_req_t sfrReq;
  rsc_irq_t irqIn;
  logic breakExec;
  logic [1:0] interruptLevel;
  logic [7:0] sfrRdata;
  logic sfrRvalid;
  rsc_rst_out_t rstOut;
  logic [15:0] spVector;
  logic [15:0] pcVector;
  logic haltMode;
  logic stopMode;
  logic wakeNoService;
  rsc_blk_t blkDisable;
  int fails = 0;
  int checks = 0;
  logic [7:0] d;
  logic v;
  logic [15:0] blkAddr [5] = '{RSC_ADDR_BLK_A, RSC_ADDR_BLK_B, RSC_ADDR_BLK_C, RSC_ADDR_BLK_D, RSC_ADDR_BLK_E};
  logic [7:0] blkMask [5] = '{RSC_MASK_A, RSC_MASK_B, RSC_MASK_C, RSC_MASK_D, RSC_MASK_E};
  localparam rsc_irq_t PEND = '{anyPending: 1'b1, default: '0};
  localparam rsc_irq_t NMI_WAKE = '{nmi: 1'b1, default: '0};
  localparam rsc_irq_t WDOG_WAKE = '{wdt: 1'b1, default: '0};
  localparam rsc_irq_t EXT_WAKE = '{anyPending: 1'b1, ext: 4'h1, extEnable: 4'h1, default: '0};
  always #5 clk = ~clk;
  rsc_ctrl i_rsc_ctrl (.clk(clk), .rst(rst), .resetPinN(resetPinN), .wdtOverflow(wdtOverflow),
    .breakExec(breakExec), .interruptLevel(interruptLevel), .irqIn(irqIn), .sfrReq(sfrReq),
    .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid), .rstOut(rstOut), .spVector(spVector),
    .pcVector(pcVector), .haltMode(haltMode), .stopMode(stopMode), .wakeNoService(wakeNoService),
    .blkDisable(blkDisable));
  rsc_cpu_model i_rsc_cpu_model (.clk(clk), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid),
    .irqIn(irqIn), .breakExec(breakExec), .interruptLevel(interruptLevel));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic wrap_up();
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic waitSig(input int which, input logic val, input int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      case (which)
        0: s = stopMode;
        1: s = haltMode;
        2: s = rstOut.cpu;
        default: s = wakeNoService;
      endcase
      if (s === val) return;
    end
    fails++;
    wrap_up();
  endtask
  task automatic chkRd(input string n, input logic [15:0] a, input logic [7:0] e);
    i_rsc_cpu_model.rd(a, d, v);
    `CHK(n, 1'b1, v)
    `CHK(n, e, d)
  endtask
  task automatic pulseWdog();
    @(posedge clk);
    wdtOverflow <= 1'b1;
    @(posedge clk);
    wdtOverflow <= 1'b0;
  endtask
  // Intervening write between the keys must not break the sequence
  task automatic tryStop(input logic [7:0] k1, input logic [7:0] k2, input rsc_irq_t pend, input logic exp);
    i_rsc_cpu_model.wr(RSC_ADDR_UNLOCK, k1);
    i_rsc_cpu_model.wr(RSC_ADDR_BLK_E, 8'h01);
    i_rsc_cpu_model.setIrq(pend);
    i_rsc_cpu_model.wr(RSC_ADDR_UNLOCK, k2);
    i_rsc_cpu_model.setIrq('0);
    i_rsc_cpu_model.wr(RSC_ADDR_STBY, 8'h02);
    #1 `CHK("stop entry", exp, stopMode)
    if (exp) begin
      i_rsc_cpu_model.setIrq(EXT_WAKE);
      waitSig(3, 1'b1, 1);
      `CHK("stop exit", 1'b0, stopMode)
      i_rsc_cpu_model.setIrq('0);
    end
  endtask
  task automatic tryHalt(input rsc_irq_t pend, input rsc_irq_t wake, input logic exp);
    i_rsc_cpu_model.setIrq(pend);
    i_rsc_cpu_model.wr(RSC_ADDR_STBY, 8'h01);
    #1 `CHK("halt entry", exp, haltMode)
    if (exp) begin
      i_rsc_cpu_model.setIrq(wake);
      if (wake.anyPending) waitSig(3, 1'b1, 1);
      else waitSig(1, 1'b0, 1);
      `CHK("halt exit", 1'b0, haltMode)
      `CHK("wake flag", wake.anyPending, wakeNoService)
    end
    i_rsc_cpu_model.setIrq('0);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK("rst out", 3'b111, rstOut)
    waitSig(2, 1'b0, 20);
    `CHK("sp vec", RSC_VEC_SP, spVector)
    `CHK("pc vec", RSC_VEC_PC, pcVector)
    chkRd("cause", RSC_ADDR_CAUSE, 8'h01);
    for (int i = 0; i < 5; i++) begin
      chkRd("blk reset", blkAddr[i], RSC_BLK_RST);
      i_rsc_cpu_model.wr(blkAddr[i], 8'hff);
      chkRd("blk bits", blkAddr[i], blkMask[i]);
    end
    `CHK("timer off", 2'b11, blkDisable.a[1:0])
    chkRd("unlock rd", RSC_ADDR_UNLOCK, RSC_ZERO);
    chkRd("stby rd", RSC_ADDR_STBY, RSC_ZERO);
    chkRd("unmapped", 16'hf0ff, RSC_ZERO);
    i_rsc_cpu_model.break_instruction(2'h0);
    #1 `CHK("brk out", 3'b100, rstOut)
    waitSig(2, 1'b0, 20);
    `CHK("brk pc", RSC_VEC_PC_BRK, pcVector)
    chkRd("brk keep", RSC_ADDR_BLK_A, RSC_MASK_A);
    i_rsc_cpu_model.break_instruction(2'h2);
    waitSig(2, 1'b0, 20);
    `CHK("brk hi pc", RSC_VEC_PC, pcVector)
    chkRd("brk cause", RSC_ADDR_CAUSE, 8'h01);
    pulseWdog();
    #1 `CHK("wdog out", 3'b111, rstOut)
    waitSig(2, 1'b0, 20);
    chkRd("wdog cause", RSC_ADDR_CAUSE, 8'h05);
    chkRd("wdog blk", RSC_ADDR_BLK_A, RSC_BLK_RST);
    i_rsc_cpu_model.wr(RSC_ADDR_CAUSE, RSC_ZERO);
    chkRd("cause clr", RSC_ADDR_CAUSE, 8'h01);
    i_rsc_cpu_model.wr(RSC_ADDR_CAUSE, 8'h04);
    chkRd("cause set", RSC_ADDR_CAUSE, 8'h05);
    @(posedge clk);
    resetPinN <= 1'b0;
    repeat (3) @(posedge clk);
    resetPinN <= 1'b1;
    @(posedge clk);
    #1 `CHK("pin out", 3'b111, rstOut)
    waitSig(2, 1'b0, 20);
    chkRd("pin cause", RSC_ADDR_CAUSE, 8'h05);
    tryStop(8'h5c, 8'ha3, '0, 1'b1);
    tryStop(8'h00, 8'h00, '0, 1'b0);
    tryStop(8'h57, 8'h33, '0, 1'b0);
    tryStop(8'h51, 8'haf, PEND, 1'b0);
    tryHalt(PEND, '0, 1'b0);
    tryHalt('0, NMI_WAKE, 1'b1);
    tryHalt('0, WDOG_WAKE, 1'b1);
    tryHalt('0, EXT_WAKE, 1'b1);
    i_rsc_cpu_model.wr(RSC_ADDR_UNLOCK, 8'h50);
    i_rsc_cpu_model.wr(RSC_ADDR_UNLOCK, 8'ha0);
    pulseWdog();
    waitSig(2, 1'b0, 20);
    i_rsc_cpu_model.wr(RSC_ADDR_STBY, 8'h02);
    #1 `CHK("armed reset", 1'b0, stopMode)
    wrap_up();
  end
endmodule // testbench
